/* hw/mrw_adapter.sv */
`timescale 1ns/1ns
`include "mrw_map.svh"
// Notes on behaviour
// - Commands reach one slave in issue order
// - Replies return to master in issue order
// - No ordering promised across different masters
// - Never a read and write reply together
// - One read reply per returned read word
// - Exactly one write reply per write command
// - Write reply only after last write beat
// - Every write completes with a write reply
// - Reply no earlier than minimum reply delay
// - Pad slave replies when master needs longer
// - Master issues only width-aligned addresses
// - Partial writes mark only written byte lanes
// - Wide master word splits into consecutive pieces
// - Narrow master reads only its slave lanes
// - Narrow master writes enable only target lanes
// - Slave width power of two, 8..1024
// - Slave word and lane from byte address
// - 32-bit word 0x04 maps to bits 63:32
// - Slave answers in its acceptance order

module mrw_adapter #(
  parameter int ADDR_W        = `MRW_ADDR_W,
  parameter int MST_W         = `MRW_MST_DATA_W,
  parameter int SLV_W         = `MRW_SLV_DATA_W,
  parameter int MST_MIN_DELAY = `MRW_MIN_DELAY_DEF,
  parameter int SLV_MIN_DELAY = `MRW_MIN_DELAY_DEF,
  parameter int TRK_DEPTH     = `MRW_TRK_DEPTH
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Master side
  mrw_if.adapter_end               mst,
  // Slave side commands
  output logic [ADDR_W-1:0]        s_addr,
  output logic                     s_read,
  output logic                     s_write,
  output logic [SLV_W-1:0]         s_wdata,
  output logic [SLV_W/8-1:0]       s_be,
  input  wire logic                s_wait,
  // Slave side replies
  input  wire logic [SLV_W-1:0]    s_rdata,
  input  wire logic                s_rvalid,
  input  wire logic                s_wrvalid,
  input  wire mrw_pkg::mrw_resp_t  s_resp
);
  import mrw_pkg::*;

  localparam int MST_B  = MST_W / 8;
  localparam int SLV_B  = SLV_W / 8;
  localparam int WIDE_W = (MST_W > SLV_W) ? MST_W : SLV_W;
  localparam int WIDE_B = WIDE_W / 8;
  localparam int PIECES = (MST_W > SLV_W) ? MST_W / SLV_W : 1;
  localparam int TRK_W  = $clog2(TRK_DEPTH);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Power of two test for width and depth checks
  function automatic bit is_pow2(input int v);
    return (v > 0) && ((v & (v - 1)) == 0);
  endfunction : is_pow2

  // Master word position inside a wider slave word
  function automatic logic [7:0] lane_of(input logic [ADDR_W-1:0] a);
    int unsigned off;
    off = 0;
    if (SLV_B > MST_B)
    begin
      off = (32'(a) % SLV_B) / MST_B;
    end
    return 8'(off);
  endfunction : lane_of

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Widths the lane logic cannot serve are refused
  if (!is_pow2(SLV_W) || SLV_W < `MRW_SLV_W_MIN || SLV_W > `MRW_SLV_W_MAX)
  begin : g_bad_slv_w
    $error("slave data width must be a power of two from 8 to 1024");
  end
  if (!is_pow2(MST_W) || MST_W < `MRW_SLV_W_MIN || MST_W > `MRW_SLV_W_MAX)
  begin : g_bad_mst_w
    $error("master data width must be a power of two from 8 to 1024");
  end
  if (MST_MIN_DELAY < 1 || MST_MIN_DELAY > `MRW_MIN_DELAY_MAX || SLV_MIN_DELAY < 1)
  begin : g_bad_delay
    $error("minimum reply delay out of range");
  end
  // Registered stages already cover any master delay up to the maximum
  if (MST_MIN_DELAY > SLV_MIN_DELAY + `MRW_ADAPT_DELAY)
  begin : g_bad_pad
    $error("master minimum reply delay exceeds adapter padding");
  end
  if (!is_pow2(TRK_DEPTH) || TRK_DEPTH < 2)
  begin : g_bad_depth
    $error("tracker depth must be a power of two of at least 2");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  mrw_trk_t            trk_mem [TRK_DEPTH];
  logic [TRK_W-1:0]    trk_wr;
  logic [TRK_W-1:0]    trk_rd;
  logic [TRK_W:0]      trk_cnt;
  logic [7:0]          piece;
  logic [WIDE_W-1:0]   wide_data;
  logic [WIDE_B-1:0]   wide_be;
  logic [7:0]          rsp_cnt;
  logic [WIDE_W-1:0]   acc;
  mrw_resp_t           status;
  logic [MST_W-1:0]    rdata_q;
  logic                rvalid_q;
  logic                wrvalid_q;
  mrw_resp_t           resp_q;

  //////////////////////////////////////////////////////////////////////////////
  // Command capture and decode

  wire                 busy       = s_read | s_write;
  wire                 trk_full   = (trk_cnt == (TRK_W+1)'(TRK_DEPTH));
  wire                 trk_empty  = (trk_cnt == '0);
  wire                 take       = (mst.m_read | mst.m_write) & ~busy & ~trk_full;
  wire mrw_kind_t      cap_kind   = mst.m_write ? MRW_WR : MRW_RD;
  wire [7:0]           cap_lane   = lane_of(mst.m_addr);
  wire [ADDR_W-1:0]    cap_word   = mst.m_addr >> $clog2(SLV_B);
  // Narrow master data lands in its own lanes of the slave word
  wire [WIDE_W-1:0]    cap_wide   = WIDE_W'(mst.m_wdata) << (int'(cap_lane) * MST_W);
  wire [WIDE_B-1:0]    cap_be     = WIDE_B'(mst.m_be) << (int'(cap_lane) * MST_B);
  wire                 last_piece = (piece == 8'(PIECES - 1));
  wire [SLV_W-1:0]     nxt_data   = SLV_W'(wide_data >> ((int'(piece) + 1) * SLV_W));
  wire [SLV_B-1:0]     nxt_be     = SLV_B'(wide_be >> ((int'(piece) + 1) * SLV_B));

  // One command in flight on the slave keeps slave order equal to issue order
  assign mst.m_wait = busy | trk_full;

  //////////////////////////////////////////////////////////////////////////////
  // Slave command sequencer

  // Master word split into pieces at consecutive slave words
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_read    <= 1'b0;
      s_write   <= 1'b0;
      s_addr    <= '0;
      s_wdata   <= '0;
      s_be      <= '0;
      piece     <= 8'h00;
      wide_data <= '0;
      wide_be   <= '0;
    end
    else if (take)
    begin
      s_read    <= (cap_kind == MRW_RD);
      s_write   <= (cap_kind == MRW_WR);
      s_addr    <= cap_word;
      s_wdata   <= SLV_W'(cap_wide);
      s_be      <= SLV_B'(cap_be);
      piece     <= 8'h00;
      wide_data <= cap_wide;
      wide_be   <= cap_be;
    end
    else if (busy && !s_wait)
    begin
      if (last_piece)
      begin
        s_read  <= 1'b0;
        s_write <= 1'b0;
      end
      else
      begin
        piece   <= piece + 8'h01;
        s_addr  <= s_addr + ADDR_W'(1);
        s_wdata <= nxt_data;
        s_be    <= nxt_be;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outstanding command tracker

  // Slave replies in acceptance order, so the head entry owns each reply
  wire                 rsp_hit  = (s_rvalid | s_wrvalid) & ~trk_empty;
  wire                 rsp_last = (rsp_cnt == 8'(PIECES - 1));
  wire                 done     = rsp_hit & rsp_last;
  wire mrw_trk_t       head     = trk_mem[trk_rd];

  // Kind and lane held until the final reply; one master, so no cross-master order
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      trk_wr  <= '0;
      trk_rd  <= '0;
      trk_cnt <= '0;
    end
    else
    begin
      if (take)
      begin
        trk_mem[trk_wr] <= '{kind: cap_kind, lane: cap_lane};
        trk_wr          <= trk_wr + TRK_W'(1);
      end
      if (done)
      begin
        trk_rd <= trk_rd + TRK_W'(1);
      end
      trk_cnt <= trk_cnt + (TRK_W+1)'(take) - (TRK_W+1)'(done);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reply assembly

  // Pieces gathered low piece first; narrow masters pick their lanes
  wire [WIDE_W-1:0]    next_acc    = acc | (WIDE_W'(s_rdata) << (int'(rsp_cnt) * SLV_W));
  wire mrw_resp_t      next_status = status | s_resp;
  wire [MST_W-1:0]     next_rdata  = MST_W'(next_acc >> (int'(head.lane) * MST_W));

  // Registered reply stage adds the delay a slower master needs
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rsp_cnt   <= 8'h00;
      acc       <= '0;
      status    <= `MRW_RESP_OKAY;
      rvalid_q  <= 1'b0;
      wrvalid_q <= 1'b0;
      rdata_q   <= '0;
      resp_q    <= `MRW_RESP_OKAY;
    end
    else
    begin
      rvalid_q  <= done & (head.kind == MRW_RD);
      wrvalid_q <= done & (head.kind == MRW_WR);
      if (done)
      begin
        rsp_cnt <= 8'h00;
        acc     <= '0;
        status  <= `MRW_RESP_OKAY;
        resp_q  <= next_status;
        if (head.kind == MRW_RD)
        begin
          rdata_q <= next_rdata;
        end
      end
      else if (rsp_hit)
      begin
        rsp_cnt <= rsp_cnt + 8'h01;
        acc     <= next_acc;
        status  <= next_status;
      end
    end
  end

  // Master reply outputs straight from the reply registers
  assign mst.m_rdata   = rdata_q;
  assign mst.m_rvalid  = rvalid_q;
  assign mst.m_wrvalid = wrvalid_q;
  assign mst.m_resp    = resp_q;

endmodule : mrw_adapter

/* hw/mrw_map.svh */
`ifndef MRW_MAP_SVH
`define MRW_MAP_SVH

// Default widths and depths
`define MRW_ADDR_W        32
`define MRW_MST_DATA_W    32
`define MRW_SLV_DATA_W    16
`define MRW_TRK_DEPTH     4
`define MRW_MAX_OUT       4

// Permitted slave data widths
`define MRW_SLV_W_MIN     8
`define MRW_SLV_W_MAX     1024

// Minimum reply delay, in clock cycles
`define MRW_MIN_DELAY_DEF 1
`define MRW_MIN_DELAY_MAX 2

// Cycles the adapter adds between command and reply
`define MRW_ADAPT_DELAY   2

// Response status codes
`define MRW_RESP_OKAY     2'h0

`endif

/* hw/mrw_pkg.sv */
package mrw_pkg;

  // Kind of a tracked command
  typedef enum logic {MRW_RD, MRW_WR} mrw_kind_t;

  // Response status field
  typedef logic [1:0] mrw_resp_t;

  // One outstanding master command
  typedef struct packed
  {
    mrw_kind_t  kind;
    logic [7:0] lane;
  } mrw_trk_t;

  // Master end command sequencer
  typedef enum logic [0:0] {MRW_IDLE, MRW_ISSUE} mrw_mst_state_t;

endpackage : mrw_pkg

/* hw/mrw_if.sv */
`timescale 1ns/1ns
`include "mrw_map.svh"

interface mrw_if #(
  parameter int ADDR_W = `MRW_ADDR_W,
  parameter int DATA_W = `MRW_MST_DATA_W
);
  // Command
  logic [ADDR_W-1:0]    m_addr;
  logic                 m_read;
  logic                 m_write;
  logic [DATA_W-1:0]    m_wdata;
  logic [DATA_W/8-1:0]  m_be;
  logic                 m_wait;
  // Replies
  logic [DATA_W-1:0]    m_rdata;
  logic                 m_rvalid;
  logic                 m_wrvalid;
  mrw_pkg::mrw_resp_t   m_resp;

  modport master_end (
    output m_addr, m_read, m_write, m_wdata, m_be,
    input  m_wait, m_rdata, m_rvalid, m_wrvalid, m_resp
  );

  modport adapter_end (
    input  m_addr, m_read, m_write, m_wdata, m_be,
    output m_wait, m_rdata, m_rvalid, m_wrvalid, m_resp
  );

endinterface : mrw_if

/* hw/mrw_master.sv */
`timescale 1ns/1ns
`include "mrw_map.svh"

module mrw_master #(
  parameter int ADDR_W    = `MRW_ADDR_W,
  parameter int DATA_W    = `MRW_MST_DATA_W,
  parameter int MIN_DELAY = `MRW_MIN_DELAY_DEF,
  parameter int MAX_OUT   = `MRW_MAX_OUT
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Bus side
  mrw_if.master_end                  bus,
  // User command
  input  wire logic                  u_req,
  input  wire logic                  u_write,
  input  wire logic [ADDR_W-1:0]     u_addr,
  input  wire logic [DATA_W-1:0]     u_wdata,
  input  wire logic [DATA_W/8-1:0]   u_be,
  output logic                       u_busy,
  // User replies
  output logic [DATA_W-1:0]          u_rdata,
  output logic                       u_rvalid,
  output logic                       u_wdone,
  output mrw_pkg::mrw_resp_t         u_resp
);
  import mrw_pkg::*;

  localparam int LOW_W = $clog2(DATA_W / 8);
  localparam int OUT_W = $clog2(MAX_OUT + 1);

  // Settings the sequencer cannot serve are refused
  if (MIN_DELAY < 1 || MIN_DELAY > `MRW_MIN_DELAY_MAX || MAX_OUT < 1 || DATA_W < `MRW_SLV_W_MIN)
  begin : g_bad_param
    $error("master end parameter out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  mrw_mst_state_t      state;
  logic [OUT_W-1:0]    outstanding;
  logic [ADDR_W-1:0]   addr_q;
  logic                read_q;
  logic                write_q;
  logic [DATA_W-1:0]   wdata_q;
  logic [DATA_W/8-1:0] be_q;

  wire                 reply     = bus.m_rvalid | bus.m_wrvalid;
  wire                 accepted  = (state == MRW_ISSUE) & ~bus.m_wait;
  wire                 room      = (outstanding < OUT_W'(MAX_OUT));
  wire                 start     = (state == MRW_IDLE) & u_req & room;
  // Low address bits cleared, so only aligned words go out
  wire [ADDR_W-1:0]    aligned   = (u_addr >> LOW_W) << LOW_W;
  // Reads take the whole word; writes keep only the lanes asked for
  wire [DATA_W/8-1:0]  lanes     = u_write ? u_be : '1;
  wire mrw_mst_state_t next_state = start ? MRW_ISSUE : (accepted ? MRW_IDLE : state);

  assign u_busy = (state == MRW_ISSUE) | ~room;

  // Command held steady until the adapter lowers its wait
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state   <= MRW_IDLE;
      addr_q  <= '0;
      read_q  <= 1'b0;
      write_q <= 1'b0;
      wdata_q <= '0;
      be_q    <= '0;
    end
    else
    begin
      state <= next_state;
      case (state)
        MRW_IDLE:
        begin
          if (start)
          begin
            addr_q  <= aligned;
            read_q  <= ~u_write;
            write_q <= u_write;
            wdata_q <= u_wdata;
            be_q    <= lanes;
          end
        end
        MRW_ISSUE:
        begin
          if (accepted)
          begin
            read_q  <= 1'b0;
            write_q <= 1'b0;
          end
        end
        default:
        begin
          read_q  <= 1'b0;
          write_q <= 1'b0;
        end
      endcase
    end
  end

  assign bus.m_addr  = addr_q;
  assign bus.m_read  = read_q;
  assign bus.m_write = write_q;
  assign bus.m_wdata = wdata_q;
  assign bus.m_be    = be_q;

  //////////////////////////////////////////////////////////////////////////////
  // Reply handling

  // Each command is retired only by its reply, writes included
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      outstanding <= '0;
      u_rvalid    <= 1'b0;
      u_wdone     <= 1'b0;
      u_rdata     <= '0;
      u_resp      <= `MRW_RESP_OKAY;
    end
    else
    begin
      outstanding <= outstanding + OUT_W'(accepted) - OUT_W'(reply);
      u_rvalid    <= bus.m_rvalid;
      // One reply per cycle: a read wins over a clashing write
      u_wdone     <= bus.m_wrvalid & ~bus.m_rvalid;
      if (reply)
      begin
        u_resp <= bus.m_resp;
      end
      if (bus.m_rvalid)
      begin
        u_rdata <= bus.m_rdata;
      end
    end
  end

endmodule : mrw_master

/* test/mrw_sva.sv */
`timescale 1ns/1ns
module mrw_sva
  import mrw_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                rst,
  // Command
  input wire logic [ADDR_W-1:0]   m_addr,
  input wire logic                m_read,
  input wire logic                m_write,
  input wire logic [DATA_W-1:0]   m_wdata,
  input wire logic [DATA_W/8-1:0] m_be,
  input wire logic                m_wait,
  // Replies
  input wire logic [DATA_W-1:0]   m_rdata,
  input wire logic                m_rvalid,
  input wire logic                m_wrvalid,
  input wire mrw_resp_t           m_resp
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic       accept;
  logic       done;
  logic [3:0] outst;
  logic       last_rd;

  // Outstanding count and kind of newest command, so replies can be tied to issue order
  assign accept = (m_read | m_write) & ~m_wait;
  assign done   = m_rvalid | m_wrvalid;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      outst   <= 4'h0;
      last_rd <= 1'b0;
    end
    else
    begin
      outst   <= outst + 4'(accept) - 4'(done);
      last_rd <= accept ? ~m_write : last_rd;
    end

  ////////////////////////////////////////////////////////////////////////////
  chk_one_reply_kind: assert property (!(m_rvalid && m_wrvalid))
    else $error("read and write reply in one cycle");
  chk_read_pulse_single: assert property (m_rvalid |=> !m_rvalid)
    else $error("read reply longer than one cycle");
  chk_reply_not_early: assert property (accept && outst == 4'h0 |=> !done [*3])
    else $error("reply earlier than allowed");
  chk_reply_has_cmd: assert property (done |-> outst != 4'h0)
    else $error("reply with nothing outstanding");
  chk_reply_kind_order: assert property (done && outst == 4'h1 |-> m_rvalid == last_rd)
    else $error("reply kind does not match command");
  chk_wait_after_take: assert property (accept |=> m_wait)
    else $error("command port not held while pieces run");
  chk_cmd_held: assert property (m_read && m_wait |=> m_read && $stable(m_addr))
    else $error("read command dropped while waiting");
  chk_addr_aligned: assert property (m_read || m_write |-> m_addr[1:0] == 2'b00)
    else $error("unaligned command address");
  chk_read_lanes_full: assert property (m_read |-> m_be == {(DATA_W/8){1'b1}})
    else $error("read without all byte lanes");
endmodule : mrw_sva

/* test/mrw_tb.sv */
`timescale 1ns/1ns
module testbench;
  import mrw_pkg::*;

  logic            sys_clk;
  logic            rst;
  logic            u_req;
  logic            u_write;
  logic [31:0]     u_addr;
  logic [31:0]     u_wdata;
  logic [3:0]      u_be;
  logic            u_busy;
  logic [31:0]     u_rdata;
  logic            u_rvalid;
  logic            u_wdone;
  mrw_resp_t       u_resp;
  logic [31:0]     s_addr;
  logic            s_read;
  logic            s_write;
  logic [15:0]     s_wdata;
  logic [1:0]      s_be;
  logic            s_wait;
  logic [15:0]     s_rdata;
  logic            s_rvalid;
  logic            s_wrvalid;
  mrw_resp_t       s_resp;
  logic            stall;
  logic            pend_rd;
  logic            pend_wr;
  logic [5:0]      pend_a;
  logic [15:0]     slv_mem [0:63];
  logic [7:0]      ref_mem [0:127];
  logic [34:0]     expq [$];
  logic [34:0]     ent;
  int              mismatches;
  int              compares;
  int              cycles;

  mrw_if bus_if ();
  mrw_master mrw_master_i (.sys_clk(sys_clk), .rst(rst), .bus(bus_if), .u_req(u_req), .u_write(u_write),
    .u_addr(u_addr), .u_wdata(u_wdata), .u_be(u_be), .u_busy(u_busy), .u_rdata(u_rdata),
    .u_rvalid(u_rvalid), .u_wdone(u_wdone), .u_resp(u_resp));
  mrw_adapter mrw_adapter_i (.sys_clk(sys_clk), .rst(rst), .mst(bus_if), .s_addr(s_addr), .s_read(s_read),
    .s_write(s_write), .s_wdata(s_wdata), .s_be(s_be), .s_wait(s_wait), .s_rdata(s_rdata),
    .s_rvalid(s_rvalid), .s_wrvalid(s_wrvalid), .s_resp(s_resp));
  mrw_sva mrw_sva_i (.sys_clk(sys_clk), .rst(rst), .m_addr(bus_if.m_addr), .m_read(bus_if.m_read),
    .m_write(bus_if.m_write), .m_wdata(bus_if.m_wdata), .m_be(bus_if.m_be), .m_wait(bus_if.m_wait),
    .m_rdata(bus_if.m_rdata), .m_rvalid(bus_if.m_rvalid), .m_wrvalid(bus_if.m_wrvalid),
    .m_resp(bus_if.m_resp));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and cycle ceiling
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave in the far place: answers each piece one cycle after taking it
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      pend_rd <= 1'b0;
      pend_wr <= 1'b0;
      pend_a  <= 6'h00;
      for (int i = 0; i < 64; i++)
        slv_mem[i] <= 16'h0000;
    end
    else
    begin
      pend_rd <= s_read & ~s_write & ~s_wait;
      pend_wr <= s_write & ~s_wait;
      pend_a  <= s_addr[5:0];
      for (int i = 0; i < 2; i++)
        if (s_write && !s_wait && s_be[i])
          slv_mem[s_addr[5:0]][i*8+:8] <= s_wdata[i*8+:8];
    end
  // Released read lines show the inverse, so stale data cannot pass
  always @(negedge sys_clk)
  begin
    s_rvalid  = pend_rd;
    s_wrvalid = pend_wr;
    s_resp    = ((pend_rd | pend_wr) & pend_a[5]) ? 2'h2 : 2'h0;
    s_rdata   = pend_rd ? slv_mem[pend_a] : (rst ? 16'h0000 : ~s_rdata);
    s_wait    = stall ? ~s_wait : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply monitor: every reply must match the oldest expectation
  always @(negedge sys_clk)
    if (!rst && (u_rvalid === 1'b1 || u_wdone === 1'b1))
    begin
      ent = (expq.size() > 0) ? expq.pop_front() : 35'h7_ffff_ffff;
      check("reply kind", 32'(ent[34]), 32'(u_wdone));
      check("reply status", 32'(ent[33:32]), 32'(u_resp));
      if (!ent[34])
        check("read data", ent[31:0], u_rdata);
    end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Called at a falling edge; leaves the request up, next call replaces it
  task automatic send(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] e;
    logic [6:0]  b;
    b = {a[6:2], 2'b00};
    e = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
    begin
      if (wr && be[i])
        ref_mem[b+i] = d[i*8+:8];
      e[i*8+:8] = ref_mem[b+i];
    end
    expq.push_back({wr, (b[6] ? 2'h2 : 2'h0), e});
    u_req   = 1'b1;
    u_write = wr;
    u_addr  = a;
    u_wdata = d;
    u_be    = be;
    while (u_busy !== 1'b0)
      @(negedge sys_clk);
    @(negedge sys_clk);
  endtask : send

  task automatic drain();
    u_req = 1'b0;
    for (int i = 0; i < 300 && expq.size() > 0; i++)
      @(negedge sys_clk);
    if (expq.size() > 0)
      check("replies left", 32'h0000_0000, 32'(expq.size()));
  endtask : drain

  task automatic test_done();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {u_req, u_write, u_addr, u_wdata, u_be} = '0;
    stall = 1'b0;
    for (int i = 0; i < 128; i++)
      ref_mem[i] = 8'h00;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    // Wide word splits low half first into consecutive slave words
    send(1'b1, 32'h0000_0010, 32'h1234_5678, 4'hF);
    drain();
    check("slave word 8", 32'h0000_5678, 32'(slv_mem[8]));
    check("slave word 9", 32'h0000_1234, 32'(slv_mem[9]));
    // Partial write then unaligned read, back to back
    send(1'b1, 32'h0000_0010, 32'hAAAA_BBBB, 4'b1100);
    send(1'b0, 32'h0000_0013, 32'h0000_0000, 4'h0);
    drain();
    check("partial lanes", 32'hAAAA_5678, {slv_mem[9], slv_mem[8]});
    // Mixed stream across the error region with a stalling slave
    stall = 1'b1;
    for (int i = 0; i < 6; i++)
      send(i % 3 != 2, 32'h38 + 32'(i * 4), 32'hC0DE_0000 + 32'(i), 4'hF);
    for (int i = 0; i < 6; i++)
      send(1'b0, 32'h38 + 32'(i * 4), 32'h0000_0000, 4'hF);
    drain();
    stall = 1'b0;
    test_done();
  end
endmodule : testbench
